/* File: bit_serial_cpu_pkg.sv */
// Constants, types and carriers shared by the CPU state block
package bit_serial_cpu_pkg;
   localparam int PC_W = 12;
   localparam int DATA_W = 8;
   localparam int DADDR_W = 8;
   localparam int STACK_DEPTH = 4;
   localparam int PROG_SPACE_BYTES = 4096;
   localparam int DATA_SPACE_BYTES = 256;
   localparam int SELFTEST_ROM_BYTES = 288;
   localparam int USER_ROM_BYTES = 1016;
   localparam int VECTOR_BYTES = 8;
   localparam int DATA_ROM_BYTES = 72;
   localparam int DATA_RAM_BYTES = 30;
   localparam logic [PC_W-1:0] RESTART_VEC_HI_ADDR = 12'hffe;
   localparam logic [PC_W-1:0] RESTART_VEC_LO_ADDR = 12'hfff;
   localparam logic [PC_W-1:0] PC_RESET = 12'h000;
   localparam logic [DADDR_W-1:0] PTR_FIRST_ADDR = 8'h80;
   localparam logic [DADDR_W-1:0] PTR_SECOND_ADDR = 8'h81;
   localparam logic [DADDR_W-1:0] SHORT_DIRECT_BASE = 8'h80;
   localparam logic [DADDR_W-1:0] SHORT_DIRECT_LAST = 8'h83;
   localparam logic [DADDR_W-1:0] TIMER_PRESCALER_ADDR = 8'hfd;
   localparam logic [DADDR_W-1:0] TIMER_COUNT_ADDR = 8'hfe;
   localparam logic [DADDR_W-1:0] ACCUMULATOR_ADDR = 8'hff;
   localparam logic [DATA_W-1:0] ACCUMULATOR_RESET = 8'h00;
   localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;
   localparam logic [DATA_W-1:0] TIMER_BYTE_RESET = 8'hff;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
   localparam logic [PC_W-1:0] PC_ONE = 12'h001;
   // Mode-decode line encodings {high,low}
   localparam logic [1:0] MODE_CODE_SELF_TEST = 2'b10;
   localparam logic [1:0] MODE_CODE_VERIFY = 2'b01;

   typedef enum logic [1:0] {MODE_SINGLE_CHIP, MODE_SELF_TEST, MODE_MEMORY_VERIFY} op_mode_t;
   typedef enum logic [2:0] {SD_NONE, SD_INC, SD_DEC, SD_LOAD, SD_STORE} sd_op_t;

   typedef struct packed {
      logic valid;
      logic we;
      logic use_ptr;
      logic ptr_sel;
      logic [DADDR_W-1:0] operand;
      logic [DATA_W-1:0] wdata;
   } data_req_t;

   typedef struct packed {
      logic we;
      logic carry;
      logic [DATA_W-1:0] result;
   } alu_res_t;

   typedef struct packed {
      logic call;
      logic int_entry;
      logic ret;
      logic return_from_interrupt;
      logic jump;
      logic incr;
      logic [PC_W-1:0] target;
   } pc_ctrl_t;
endpackage

/* File: data_space_mem.sv */
// Byte memory behind the ordinary data-space locations, registered read
module data_space_mem
   import bit_serial_cpu_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic we_in,
   input wire logic [DADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   output logic [DATA_W-1:0] rdata_out
);
   logic [DATA_W-1:0] mem_reg [DATA_SPACE_BYTES];

   // No reset on the array so it maps onto plain RAM
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem_reg[addr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= mem_reg[addr_in];
      end
   end
endmodule

/* File: bit_serial_cpu_state.sv */
// Architectural state of the bit-serial CPU: PC, stack, flags, mode, data registers
// Functional notes
// - Reset loads PC from vector FFE-FFF
// - Mode pin low: single-chip mode
// - Mode pin high: latch decoded mode lines
// - Opcodes fetched only from program space
// - 4096 program bytes, 256 data bytes
// - Data address from operand or pointer
// - PC 12 bits, next word address
// - Accumulator lives at data FF
// - Pointers at 80/81, ordinary RAM access
// - Short direct ops on 80-83
// - Data space holds registers, ROM, RAM
// - Program space: self-test, user ROM, vectors
// - Carry follows ALU carry or borrow
// - Bit test copies bit into carry
// - Zero from result; bit test keeps it
// - Separate flag sets, switched on interrupts
// - Switch keeps flags; reset clears both
// - Push PC, shift stack deeper
// - Return pops top into PC
// - Four levels; bottom repeats when overpulled
// - Timer bytes at FD/FE read/write
module bit_serial_cpu_state (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic mode_select_pin_in,
   input wire logic mode_decode_line_low_in,
   input wire logic mode_decode_line_high_in,
   input wire logic irq_req_n_in,
   input wire logic [bit_serial_cpu_pkg::DATA_W-1:0] prog_rdata_in,
   input wire bit_serial_cpu_pkg::pc_ctrl_t pc_ctrl_in,
   input wire bit_serial_cpu_pkg::data_req_t data_req_in,
   input wire bit_serial_cpu_pkg::alu_res_t alu_res_in,
   input wire logic bit_test_in,
   input wire logic bit_value_in,
   input wire bit_serial_cpu_pkg::sd_op_t sd_op_in,
   input wire logic [1:0] sd_index_in,
   output logic [bit_serial_cpu_pkg::PC_W-1:0] prog_addr_out,
   output logic fetch_en_out,
   output logic [bit_serial_cpu_pkg::PC_W-1:0] pc_out,
   output logic [bit_serial_cpu_pkg::DATA_W-1:0] pc_low_byte_out,
   output logic [3:0] pc_high_nibble_out,
   output bit_serial_cpu_pkg::op_mode_t op_mode_out,
   output logic mode_valid_out,
   output logic [bit_serial_cpu_pkg::DADDR_W-1:0] data_addr_out,
   output logic [bit_serial_cpu_pkg::DATA_W-1:0] data_rdata_out,
   output logic data_rvalid_out,
   output logic [bit_serial_cpu_pkg::DATA_W-1:0] accumulator_out,
   output logic [bit_serial_cpu_pkg::DATA_W-1:0] timer_prescaler_out,
   output logic [bit_serial_cpu_pkg::DATA_W-1:0] timer_count_out,
   output logic flag_carry_out,
   output logic flag_zero_out,
   output logic int_mode_out,
   output logic irq_level_out
);
   import bit_serial_cpu_pkg::*;

   typedef enum logic [1:0] {ST_VEC_HI, ST_VEC_LO, ST_VEC_LOAD, ST_RUN} boot_state_t;

   boot_state_t state_reg;
   logic [PC_W-1:0] pc_reg;
   logic [3:0] vec_hi_reg;
   logic [PC_W-1:0] stack_reg [STACK_DEPTH];
   logic [DATA_W-1:0] acc_reg;
   logic [DATA_W-1:0] sd_reg [4];
   logic [DATA_W-1:0] prescaler_reg;
   logic [DATA_W-1:0] count_reg;
   logic carry_reg [2];
   logic zero_reg [2];
   logic int_mode_reg;
   op_mode_t mode_reg;
   logic mode_valid_reg;
   logic irq_meta_reg;
   logic irq_sync_reg;
   logic reg_hit_reg;
   logic [DATA_W-1:0] reg_val_reg;
   logic rvalid_reg;
   logic [DADDR_W-1:0] data_addr;
   logic running;
   logic push;
   logic pull;
   logic data_wr;
   logic mem_we;
   logic [DATA_W-1:0] mem_rdata;

   function automatic logic is_reg_addr(input logic [DADDR_W-1:0] a);
      return (a >= SHORT_DIRECT_BASE && a <= SHORT_DIRECT_LAST) || a == TIMER_PRESCALER_ADDR
         || a == TIMER_COUNT_ADDR || a == ACCUMULATOR_ADDR;
   endfunction

   function automatic logic is_sd_addr(input logic [DADDR_W-1:0] a);
      return a >= SHORT_DIRECT_BASE && a <= SHORT_DIRECT_LAST;
   endfunction

   function automatic op_mode_t decode_mode(input logic sel, input logic hi, input logic lo);
      if (!sel) begin
         return MODE_SINGLE_CHIP;
      end else if ({hi, lo} == MODE_CODE_SELF_TEST) begin
         return MODE_SELF_TEST;
      end else if ({hi, lo} == MODE_CODE_VERIFY) begin
         return MODE_MEMORY_VERIFY;
      end
      return MODE_SINGLE_CHIP;
   endfunction

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   assign running = state_reg == ST_RUN;
   assign push = running && (pc_ctrl_in.call || pc_ctrl_in.int_entry);
   assign pull = running && (pc_ctrl_in.ret || pc_ctrl_in.return_from_interrupt);

   // Mode straps caught at the first edge after reset release
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode_reg <= MODE_SINGLE_CHIP;
         mode_valid_reg <= 1'b0;
      end else if (!mode_valid_reg) begin
         mode_reg <= decode_mode(mode_select_pin_in, mode_decode_line_high_in,
                                 mode_decode_line_low_in);
         mode_valid_reg <= 1'b1;
      end
   end

   assign op_mode_out = mode_reg;
   assign mode_valid_out = mode_valid_reg;

   // Boot sequence: read vector, then run
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= ST_VEC_HI;
      end else begin
         unique case (state_reg)
            ST_VEC_HI: state_reg <= ST_VEC_LO;
            ST_VEC_LO: state_reg <= ST_VEC_LOAD;
            ST_VEC_LOAD: state_reg <= ST_RUN;
            ST_RUN: state_reg <= ST_RUN;
         endcase
      end
   end

   // Program memory answers one cycle after the address
   always_comb begin
      unique case (state_reg)
         ST_VEC_HI: prog_addr_out = RESTART_VEC_HI_ADDR;
         ST_VEC_LO: prog_addr_out = RESTART_VEC_LO_ADDR;
         default: prog_addr_out = pc_reg;
      endcase
   end

   assign fetch_en_out = running;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         vec_hi_reg <= 4'h0;
      end else if (state_reg == ST_VEC_LO) begin
         vec_hi_reg <= prog_rdata_in[3:0];
      end
   end

   // Program counter; a return beats a call in the same cycle
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pc_reg <= PC_RESET;
      end else if (state_reg == ST_VEC_LOAD) begin
         pc_reg <= {vec_hi_reg, prog_rdata_in};
      end else if (pull) begin
         pc_reg <= stack_reg[0];
      end else if (running && (push || pc_ctrl_in.jump)) begin
         pc_reg <= pc_ctrl_in.target;
      end else if (running && pc_ctrl_in.incr) begin
         pc_reg <= pc_reg + PC_ONE;
      end
   end

   assign pc_out = pc_reg;
   assign pc_low_byte_out = pc_reg[7:0];
   assign pc_high_nibble_out = pc_reg[11:8];

   // Hidden stack, unreset on purpose so it maps onto RAM
   always_ff @(posedge clk_in) begin
      if (pull) begin
         for (int i = 0; i < STACK_DEPTH - 1; i++) begin
            stack_reg[i] <= stack_reg[i+1];
         end
      end else if (push) begin
         stack_reg[0] <= pc_reg;
         for (int i = 1; i < STACK_DEPTH; i++) begin
            stack_reg[i] <= stack_reg[i-1];
         end
      end
   end

   // Flag set select
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         int_mode_reg <= 1'b0;
      end else if (running && pc_ctrl_in.return_from_interrupt) begin
         int_mode_reg <= 1'b0;
      end else if (running && pc_ctrl_in.int_entry) begin
         int_mode_reg <= 1'b1;
      end
   end

   // Only the active set moves; switching leaves both intact
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         carry_reg[0] <= 1'b0;
         carry_reg[1] <= 1'b0;
         zero_reg[0] <= 1'b0;
         zero_reg[1] <= 1'b0;
      end else if (running) begin
         if (bit_test_in) begin
            carry_reg[int_mode_reg] <= bit_value_in;
         end else if (alu_res_in.we) begin
            carry_reg[int_mode_reg] <= alu_res_in.carry;
            zero_reg[int_mode_reg] <= alu_res_in.result == 8'h00;
         end
      end
   end

   assign flag_carry_out = carry_reg[int_mode_reg];
   assign flag_zero_out = zero_reg[int_mode_reg];
   assign int_mode_out = int_mode_reg;
   // Interrupt pin may change at any time
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_meta_reg <= 1'b0;
         irq_sync_reg <= 1'b0;
      end else begin
         irq_meta_reg <= !irq_req_n_in;
         irq_sync_reg <= irq_meta_reg;
      end
   end

   assign irq_level_out = irq_sync_reg;
   // Data space address
   always_comb begin
      if (data_req_in.use_ptr) begin
         data_addr = data_req_in.ptr_sel ? sd_reg[1] : sd_reg[0];
      end else begin
         data_addr = data_req_in.operand;
      end
   end

   assign data_addr_out = data_addr;
   assign data_wr = running && data_req_in.valid && data_req_in.we;
   assign mem_we = data_wr && !is_reg_addr(data_addr);

   // Pointers and counter bytes; bus write wins over a short-direct op
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < 4; i++) begin
            sd_reg[i] <= POINTER_RESET;
         end
      end else if (data_wr && is_sd_addr(data_addr)) begin
         sd_reg[data_addr[1:0]] <= data_req_in.wdata;
      end else if (running) begin
         unique case (sd_op_in)
            SD_INC: sd_reg[sd_index_in] <= sd_reg[sd_index_in] + DATA_ONE;
            SD_DEC: sd_reg[sd_index_in] <= sd_reg[sd_index_in] - DATA_ONE;
            SD_STORE: sd_reg[sd_index_in] <= acc_reg;
            SD_NONE, SD_LOAD: ;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_reg <= ACCUMULATOR_RESET;
      end else if (data_wr && data_addr == ACCUMULATOR_ADDR) begin
         acc_reg <= data_req_in.wdata;
      end else if (running && sd_op_in == SD_LOAD) begin
         acc_reg <= sd_reg[sd_index_in];
      end
   end

   assign accumulator_out = acc_reg;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prescaler_reg <= TIMER_BYTE_RESET;
         count_reg <= TIMER_BYTE_RESET;
      end else if (data_wr) begin
         if (data_addr == TIMER_PRESCALER_ADDR) begin
            prescaler_reg <= data_req_in.wdata;
         end
         if (data_addr == TIMER_COUNT_ADDR) begin
            count_reg <= data_req_in.wdata;
         end
      end
   end

   assign timer_prescaler_out = prescaler_reg;
   assign timer_count_out = count_reg;
   // Read path: register bytes captured here, others from memory
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_hit_reg <= 1'b0;
         reg_val_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= running && data_req_in.valid && !data_req_in.we;
         reg_hit_reg <= is_reg_addr(data_addr);
         if (is_sd_addr(data_addr)) begin
            reg_val_reg <= sd_reg[data_addr[1:0]];
         end else if (data_addr == TIMER_PRESCALER_ADDR) begin
            reg_val_reg <= prescaler_reg;
         end else if (data_addr == TIMER_COUNT_ADDR) begin
            reg_val_reg <= count_reg;
         end else begin
            reg_val_reg <= acc_reg;
         end
      end
   end

   assign data_rdata_out = reg_hit_reg ? reg_val_reg : mem_rdata;
   assign data_rvalid_out = rvalid_reg;

   data_space_mem u_mem (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .we_in(mem_we),
      .addr_in(data_addr),
      .wdata_in(data_req_in.wdata),
      .rdata_out(mem_rdata)
   );

   sequence vec_fetch_s;
      state_reg == ST_VEC_HI ##1 state_reg == ST_VEC_LO ##1 state_reg == ST_VEC_LOAD;
   endsequence

   sequence acc_read_s;
      running && data_req_in.valid && !data_req_in.we && data_addr == ACCUMULATOR_ADDR;
   endsequence

   AST_VEC_ADDR: assert property (state_reg == ST_VEC_HI |-> prog_addr_out == RESTART_VEC_HI_ADDR
      ##1 prog_addr_out == RESTART_VEC_LO_ADDR) else $error("restart vector address wrong");
   AST_VEC_LOAD: assert property (vec_fetch_s |=> pc_reg[11:8] == $past(prog_rdata_in[3:0], 2)
      && pc_reg[7:0] == $past(prog_rdata_in)) else $error("pc not loaded from vector");
   AST_MODE_LOW: assert property ($rose(mode_valid_reg) && !$past(mode_select_pin_in)
      |-> mode_reg == MODE_SINGLE_CHIP) else $error("mode pin low did not give single-chip");
   AST_MODE_HIGH: assert property ($rose(mode_valid_reg) && $past(mode_select_pin_in)
      && $past(mode_decode_line_high_in && !mode_decode_line_low_in) |-> mode_reg == MODE_SELF_TEST)
      else $error("self-test decode wrong");
   AST_FETCH_PC: assert property (fetch_en_out |-> prog_addr_out == pc_reg)
      else $error("fetch not from pc");
   AST_ACC_READ: assert property (acc_read_s ##0 (sd_op_in != SD_LOAD)
      |=> data_rvalid_out && data_rdata_out == $past(acc_reg)) else $error("accumulator read wrong");
   AST_PTR_WRITE: assert property (data_wr && data_addr == PTR_FIRST_ADDR
      |=> sd_reg[0] == $past(data_req_in.wdata)) else $error("pointer write lost");
   AST_SD_INC: assert property (running && sd_op_in == SD_INC && !data_wr && sd_index_in == 2'd2
      |=> sd_reg[2] == $past(sd_reg[2]) + 8'h01) else $error("short direct increment wrong");
   AST_CARRY: assert property (running && alu_res_in.we && !bit_test_in && !pc_ctrl_in.int_entry
      && !pc_ctrl_in.return_from_interrupt |=> flag_carry_out == $past(alu_res_in.carry)) else $error("carry not from alu");
   AST_BITTEST_Z: assert property (running && bit_test_in && !pc_ctrl_in.int_entry && !pc_ctrl_in.return_from_interrupt
      |=> flag_zero_out == $past(flag_zero_out) && flag_carry_out == $past(bit_value_in))
      else $error("bit test flags wrong");
   AST_FLAG_KEEP: assert property (running && pc_ctrl_in.int_entry && !pc_ctrl_in.return_from_interrupt && !int_mode_reg
      |=> int_mode_reg && flag_carry_out == $past(carry_reg[1]) && flag_zero_out == $past(zero_reg[1]))
      else $error("flag set did not switch");
   AST_SWITCH_KEEP: assert property (running && pc_ctrl_in.return_from_interrupt && !alu_res_in.we && !bit_test_in
      |=> !int_mode_reg && carry_reg[1] == $past(carry_reg[1]) && flag_carry_out == $past(carry_reg[0]))
      else $error("switch altered stored flags");
   AST_PUSH: assert property (push && !pull |=> stack_reg[0] == $past(pc_reg)
      && stack_reg[1] === $past(stack_reg[0]) && stack_reg[3] === $past(stack_reg[2])) else $error("push wrong");
   AST_PULL: assert property (pull |=> pc_reg === $past(stack_reg[0])
      && stack_reg[0] === $past(stack_reg[1]) && stack_reg[3] === $past(stack_reg[3])) else $error("pull wrong");
endmodule

/* File: prog_mem_model.sv */
// Program memory model: restart vector plus filler bytes, one-cycle registered read
module prog_mem_model #(
   parameter logic [bit_serial_cpu_pkg::PC_W-1:0] VECTOR = 12'h5a3
) (
   input wire logic clk_in,
   input wire logic [bit_serial_cpu_pkg::PC_W-1:0] addr_in,
   output logic [bit_serial_cpu_pkg::DATA_W-1:0] rdata_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import bit_serial_cpu_pkg::*;

   // 4096 byte addresses, vector pair at the top
   always_ff @(posedge clk_in) begin
      case (addr_in)
         RESTART_VEC_HI_ADDR: rdata_out <= {4'h0, VECTOR[11:8]};
         RESTART_VEC_LO_ADDR: rdata_out <= VECTOR[7:0];
         // Filler tracks the address so a stale byte never looks right
         default: rdata_out <= ~addr_in[7:0];
      endcase
   end
endmodule

/* File: bit_serial_cpu_state_tb.sv */
// Self-checking testbench for the CPU state block
module bit_serial_cpu_state_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import bit_serial_cpu_pkg::*;

   localparam logic [PC_W-1:0] VEC = 12'h5a3;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic mode_select_pin = 1'b0;
   logic mlo = 1'b0;
   logic mhi = 1'b0;
   logic irq_n = 1'b1;
   logic bit_test = 1'b0;
   logic bit_value = 1'b0;
   logic [1:0] sd_index = 2'h0;
   sd_op_t sd_op = SD_NONE;
   pc_ctrl_t pc_ctrl = '0;
   data_req_t data_req = '0;
   alu_res_t alu_res = '0;
   logic [DATA_W-1:0] prog_rdata, pc_low, rdata, acc, tpre, tcnt;
   logic [PC_W-1:0] prog_addr, pc;
   logic [3:0] pc_high;
   logic [DADDR_W-1:0] daddr;
   op_mode_t op_mode;
   logic fetch_en, mode_valid, rvalid, carry, zero, int_mode, irq_level;
   int errors = 0;
   int n_compared = 0;

   always #2 clk = ~clk;

   prog_mem_model #(.VECTOR(VEC)) prog_mem (.clk_in(clk), .addr_in(prog_addr), .rdata_out(prog_rdata));

   bit_serial_cpu_state DUT (.clk_in(clk), .resetn_in(resetn), .mode_select_pin_in(mode_select_pin),
      .mode_decode_line_low_in(mlo), .mode_decode_line_high_in(mhi), .irq_req_n_in(irq_n),
      .prog_rdata_in(prog_rdata), .pc_ctrl_in(pc_ctrl), .data_req_in(data_req), .alu_res_in(alu_res),
      .bit_test_in(bit_test), .bit_value_in(bit_value), .sd_op_in(sd_op), .sd_index_in(sd_index),
      .prog_addr_out(prog_addr), .fetch_en_out(fetch_en), .pc_out(pc), .pc_low_byte_out(pc_low),
      .pc_high_nibble_out(pc_high), .op_mode_out(op_mode), .mode_valid_out(mode_valid),
      .data_addr_out(daddr), .data_rdata_out(rdata), .data_rvalid_out(rvalid), .accumulator_out(acc),
      .timer_prescaler_out(tpre), .timer_count_out(tcnt), .flag_carry_out(carry), .flag_zero_out(zero),
      .int_mode_out(int_mode), .irq_level_out(irq_level));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("Compared %0d values, %0d mismatches", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic do_reset(input logic m, input logic hi, input logic lo);
      int n;
      @(posedge clk);
      mode_select_pin <= m;
      mhi <= hi;
      mlo <= lo;
      resetn <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      check("carry_rst", carry, 1'b0);
      check("zero_rst", zero, 1'b0);
      check("timer_rst", {tpre, tcnt}, 16'hffff);
      check("fetch_rst", fetch_en, 1'b0);
      @(posedge clk);
      resetn <= 1'b1;
      n = 0;
      while (fetch_en !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("pc_boot", pc, VEC);
      check("pc_parts", {pc_high, pc_low}, VEC);
      check("mode_valid", mode_valid, 1'b1);
   endtask

   // Strobes last exactly one cycle; checks run after the taking edge settles
   task automatic cmd(input pc_ctrl_t c);
      @(posedge clk);
      pc_ctrl <= c;
      @(posedge clk);
      pc_ctrl <= '0;
      #1;
   endtask

   task automatic dreq(input data_req_t d);
      @(posedge clk);
      data_req <= d;
      @(posedge clk);
      data_req <= '0;
      #1;
   endtask

   task automatic flags(input logic we, input logic c, input logic [7:0] r, input logic bt, input logic bv);
      @(posedge clk);
      alu_res <= '{we:we, carry:c, result:r};
      bit_test <= bt;
      bit_value <= bv;
      @(posedge clk);
      alu_res <= '0;
      bit_test <= 1'b0;
      #1;
   endtask

   task automatic sd(input sd_op_t s, input logic [1:0] i);
      @(posedge clk);
      sd_op <= s;
      sd_index <= i;
      @(posedge clk);
      sd_op <= SD_NONE;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      dreq('{valid:1'b1, we:1'b1, operand:a, wdata:v, default:'0});
   endtask

   task automatic rd(input logic p, input logic s, input logic [7:0] a, input logic [7:0] exp);
      dreq('{valid:1'b1, use_ptr:p, ptr_sel:s, operand:a, default:'0});
      check("rvalid", rvalid, 1'b1);
      check("rdata", rdata, exp);
   endtask

   task automatic mode_test();
      logic [2:0] straps [5] = '{3'b010, 3'b100, 3'b110, 3'b101, 3'b111};
      op_mode_t exp [5] = '{MODE_SINGLE_CHIP, MODE_SINGLE_CHIP, MODE_SELF_TEST, MODE_MEMORY_VERIFY,
         MODE_SINGLE_CHIP};
      for (int i = 0; i < 5; i++) begin
         do_reset(straps[i][2], straps[i][1], straps[i][0]);
         check("op_mode", op_mode, exp[i]);
      end
   endtask

   task automatic data_test();
      wr(8'hff, 8'h3c);
      check("acc", acc, 8'h3c);
      rd(1'b0, 1'b0, 8'hff, 8'h3c);
      wr(8'h80, 8'h20);
      wr(8'h20, 8'h77);
      rd(1'b0, 1'b0, 8'h80, 8'h20);
      rd(1'b1, 1'b0, 8'h00, 8'h77);
      wr(8'h81, 8'hff);
      // Address path only: no access is made
      @(posedge clk);
      data_req <= '{use_ptr:1'b1, ptr_sel:1'b1, default:'0};
      #1;
      check("daddr", daddr, 8'hff);
      rd(1'b1, 1'b1, 8'h00, 8'h3c);
      wr(8'hfd, 8'h12);
      wr(8'hfe, 8'h34);
      check("timer", {tpre, tcnt}, 16'h1234);
      rd(1'b0, 1'b0, 8'hfd, 8'h12);
      sd(SD_INC, 2'h2);
      rd(1'b0, 1'b0, 8'h82, 8'h01);
      sd(SD_DEC, 2'h3);
      rd(1'b0, 1'b0, 8'h83, 8'hff);
      sd(SD_STORE, 2'h0);
      rd(1'b0, 1'b0, 8'h80, 8'h3c);
      sd(SD_LOAD, 2'h1);
      check("acc_load", acc, 8'hff);
   endtask

   task automatic flag_test();
      do_reset(1'b0, 1'b0, 1'b0);
      flags(1'b1, 1'b1, 8'h00, 1'b0, 1'b0);
      check("cz_alu", {carry, zero}, 2'b11);
      flags(1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
      check("cz_btest", {carry, zero}, 2'b01);
      cmd('{int_entry:1'b1, target:12'h300, default:'0});
      check("int_mode", int_mode, 1'b1);
      check("cz_int", {carry, zero}, 2'b00);
      check("prog_addr", prog_addr, 12'h300);
      flags(1'b1, 1'b1, 8'h05, 1'b0, 1'b0);
      check("cz_int_alu", {carry, zero}, 2'b10);
      cmd('{return_from_interrupt:1'b1, default:'0});
      check("int_mode_ret", int_mode, 1'b0);
      check("cz_prog", {carry, zero}, 2'b01);
      check("pc_rti", pc, VEC);
   endtask

   task automatic stack_test();
      cmd('{jump:1'b1, target:12'hfff, default:'0});
      check("pc_jump", pc, 12'hfff);
      cmd('{incr:1'b1, default:'0});
      check("pc_wrap", pc, 12'h000);
      // Five pushes: the first return address falls out of the bottom
      for (int i = 1; i <= 5; i++) begin
         cmd('{call:1'b1, target:12'h100 + 12'(i), default:'0});
         check("pc_call", pc, 12'h100 + 12'(i));
      end
      for (int i = 0; i < 5; i++) begin
         cmd('{ret:1'b1, default:'0});
         check("pc_ret", pc, (i < 4) ? 12'h104 - 12'(i) : 12'h101);
         check("prog_addr", prog_addr, (i < 4) ? 12'h104 - 12'(i) : 12'h101);
      end
   endtask

   task automatic irq_test();
      int n;
      @(posedge clk);
      irq_n <= 1'b0;
      n = 0;
      while (irq_level !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("irq_level", irq_level, 1'b1);
      @(posedge clk);
      irq_n <= 1'b1;
   endtask

   initial begin
      #40000;
      errors++;
      wrap_up();
   end

   initial begin
      mode_test();
      data_test();
      flag_test();
      stack_test();
      irq_test();
      wrap_up();
   end
endmodule
